// ===== hw/ccs_core_clock_select.sv
// Core clock source selector: picks bus or fast clock for the core.
// Assumes bus_clock and fast_clock are levels synchronous to clk_sys;
// the selected clock is rebuilt as a registered level on core_clock_out.
`timescale 1ns/1ps
`default_nettype none

module ccs_core_clock_select
   import ccs_pkg::*;
(
   input  wire  logic       clk_sys,              // System clock, 40 MHz
   input  wire  logic       rst_n,                // Asynchronous reset, active low
   input  wire  logic       bus_clock,            // Bus clock level
   input  wire  logic       fast_clock,           // Fast clock level
   input  wire  logic       not_bus_only_bit,     // High leaves bus-only mode
   input  wire  logic       async_select_bit,     // High picks asynchronous mode outside bus-only mode
   input  wire  logic [1:0] access_type,          // External access in progress
   output var   logic       core_clock_out,       // Selected core clock
   output var   logic       bus_if_clock,         // Bus interface clock
   output var   logic       core_on_fast,         // Core runs on fast clock
   output var   logic       bus_clock_only_mode   // Bus-only mode active
);

   // ---------------------------------------------------------------
   // Mode and clock samples
   // ---------------------------------------------------------------
   logic       not_bus_only_q;
   logic       not_bus_only_d;
   logic       async_q;
   logic       async_d;
   logic       bus_s_q;
   logic       bus_s_d;
   logic       fast_s_q;
   logic       fast_s_d;
   logic       need_bus;
   logic       want_fast;

   always_comb begin
      not_bus_only_d = not_bus_only_bit;
      async_d        = async_select_bit & not_bus_only_bit;
      bus_s_d        = bus_clock;
      // Fast clock is masked out entirely in bus-only mode
      fast_s_d       = fast_clock & not_bus_only_bit;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         not_bus_only_q <= RST_NOT_BUS_ONLY;
         async_q        <= RST_ASYNC_SEL;
         bus_s_q        <= RST_LEVEL;
         fast_s_q       <= RST_LEVEL;
      end else begin
         not_bus_only_q <= not_bus_only_d;
         async_q        <= async_d;
         bus_s_q        <= bus_s_d;
         fast_s_q       <= fast_s_d;
      end
   end

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   // The selector relies on three one-hot state codes
   if ($bits(ccs_state_t) != 3) begin : g_bad_state
      $error("selector state code must be three bits wide");
   end

   // Access decoding below assumes two-bit access codes
   if ($bits(ACC_READ) != 2) begin : g_bad_access
      $error("access code must be two bits wide");
   end

   // ---------------------------------------------------------------
   // Access decoding
   // ---------------------------------------------------------------
   // Nonbuffered writes and reads hold the core on the
   // bus clock; a buffered write drains without slowing the core
   function automatic logic needs_bus_clock(input logic [1:0] acc);
      logic hit;
      hit = 1'h0;
      case (acc)
         ACC_UNBUF_WRITE: hit = 1'h1;
         ACC_READ:        hit = 1'h1;
         default:         hit = 1'h0;
      endcase
      return hit;
   endfunction

   // Level of the source that one select value names
   function automatic logic source_level(input logic sel_fast,
                                         input logic fast_lvl,
                                         input logic bus_lvl);
      return sel_fast ? fast_lvl : bus_lvl;
   endfunction

   always_comb begin
      need_bus  = needs_bus_clock(access_type);
      want_fast = not_bus_only_q && !need_bus;
   end

   // ---------------------------------------------------------------
   // Glitch-free selector
   // ---------------------------------------------------------------
   ccs_state_t state_q;
   ccs_state_t state_d;
   logic       target_fast_q;
   logic       target_fast_d;
   logic       seen_high_q;
   logic       seen_high_d;
   logic       out_q;
   logic       out_d;
   logic       dest_s;

   always_comb begin
      state_d       = state_q;
      target_fast_d = target_fast_q;
      seen_high_d   = seen_high_q;
      out_d         = out_q;
      dest_s        = source_level(target_fast_q, fast_s_q, bus_s_q);
      unique case (state_q)
         ST_BUS: begin
            out_d = bus_s_q;
            // Leave only while the old source is low: no short high
            if (want_fast && !bus_s_q) begin
               state_d       = ST_PARK;
               target_fast_d = 1'h1;
               seen_high_d   = 1'h0;
               out_d         = 1'h0;
            end
         end
         ST_FAST: begin
            out_d = fast_s_q;
            if (!want_fast && !fast_s_q) begin
               state_d       = ST_PARK;
               target_fast_d = 1'h0;
               seen_high_d   = 1'h0;
               out_d         = 1'h0;
            end
         end
         ST_PARK: begin
            // Output held low until the destination is safely low
            out_d = 1'h0;
            if (want_fast != target_fast_q) begin
               target_fast_d = want_fast;
               seen_high_d   = 1'h0;
            end else begin
               seen_high_d = seen_high_q | dest_s;
               // Sync: destination low suffices, at most one phase
               // Async: wait for a falling edge, at most one cycle
               if (!dest_s && (!async_q || seen_high_q)) begin
                  state_d = target_fast_q ? ST_FAST : ST_BUS;
               end
            end
         end
      endcase
   end

   // No timers anywhere: stopped clocks simply freeze the selector
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q       <= ST_BUS;
         target_fast_q <= 1'h0;
         seen_high_q   <= 1'h0;
         out_q         <= RST_LEVEL;
      end else begin
         state_q       <= state_d;
         target_fast_q <= target_fast_d;
         seen_high_q   <= seen_high_d;
         out_q         <= out_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Every output leaves from a flip-flop so that no decode glitch
   // reaches the pins; the flags trail the selector by one edge
   logic bus_if_q;
   logic on_fast_q;
   logic bus_only_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus_if_q   <= RST_LEVEL;
         on_fast_q  <= 1'h0;
         bus_only_q <= 1'h1;
      end else begin
         bus_if_q   <= bus_s_q;
         on_fast_q  <= (state_q == ST_FAST);
         bus_only_q <= !not_bus_only_q;
      end
   end

   assign core_clock_out      = out_q;
   assign bus_if_clock        = bus_if_q;
   assign core_on_fast        = on_fast_q;
   assign bus_clock_only_mode = bus_only_q;

endmodule // ccs_core_clock_select

`default_nettype wire

// ===== hw/ccs_pkg.sv
// Package for the core clock source selector: access codes, reset values, states.
// Assumes both clock inputs are sampled as levels on clk_sys.
package ccs_pkg;

   // ---------------------------------------------------------------
   // External memory access codes
   // ---------------------------------------------------------------
   localparam logic [1:0] ACC_NONE        = 2'h0;
   localparam logic [1:0] ACC_BUF_WRITE   = 2'h1;
   localparam logic [1:0] ACC_UNBUF_WRITE = 2'h2;
   localparam logic [1:0] ACC_READ        = 2'h3;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic RST_NOT_BUS_ONLY = 1'h0;
   localparam logic RST_ASYNC_SEL    = 1'h0;
   localparam logic RST_LEVEL        = 1'h0;

   // ---------------------------------------------------------------
   // Selector states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_BUS  = 3'h1,
      ST_FAST = 3'h2,
      ST_PARK = 3'h4
   } ccs_state_t;

endpackage

// ===== dv/ccs_clk_gen.sv
// Partner model: clock generator feeding bus and fast clock levels.
// Assumes one clk_sys domain; both clocks freeze while run is low.
`timescale 1ns/1ps
`default_nettype none
module ccs_clk_gen (
   input  wire logic clk_sys,    // System clock
   input  wire logic rst_n,      // Reset, active low
   input  wire logic run,        // Low halts both clocks
   output var  logic bus_clock,  // Bus clock, eight cycles
   output var  logic fast_clock  // Fast clock, two cycles
);
   logic [2:0] ph_q;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ph_q <= 3'h0;
      end else if (run) begin
         ph_q <= ph_q + 3'h1;
      end
   end
   // Fast is four times bus and high at every bus edge
   assign bus_clock  = ph_q[2];
   assign fast_clock = ~ph_q[0];
endmodule // ccs_clk_gen
`default_nettype wire

// ===== dv/ccs_chk_assertions.sv
// Checker for the core clock selector, sees the top ports only.
// Assumes clock inputs are levels sampled on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ccs_chk (
   input wire logic       clk_sys, rst_n, bus_clock, fast_clock,  // Inputs
   input wire logic       not_bus_only_bit, async_select_bit,     // Mode
   input wire logic [1:0] access_type,                            // Access
   input wire logic       core_clock_out, bus_if_clock,           // Outputs
   input wire logic       core_on_fast, bus_clock_only_mode       // Flags
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [4:0] slow_q, fast_q;
   wire logic  want = not_bus_only_bit && !access_type[1];
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slow_q <= 5'h00;
         fast_q <= 5'h00;
      end else begin
         slow_q <= want ? 5'h00 : slow_q + {4'h0, slow_q != 5'h1F};
         fast_q <= !want ? 5'h00 : fast_q + {4'h0, fast_q != 5'h1F};
      end
   end
   property p_rst; $rose(rst_n) |-> bus_clock_only_mode && !core_on_fast; endproperty
   a_rst: assert property (p_rst) else $error("mode wrong after reset");
   property p_bif; $past(rst_n, 3) |-> bus_if_clock == $past(bus_clock, 2); endproperty
   a_bif: assert property (p_bif) else $error("bus side clock wrong");
   property p_only; !not_bus_only_bit [*3] |-> bus_clock_only_mode; endproperty
   a_only: assert property (p_only) else $error("bus only flag low");
   property p_mode; not_bus_only_bit [*3] |-> !bus_clock_only_mode; endproperty
   a_mode: assert property (p_mode) else $error("bus only flag high");
   property p_slow; slow_q >= 5'h10 |-> !core_on_fast && core_clock_out == $past(bus_clock, 2);
   endproperty
   a_slow: assert property (p_slow) else $error("core not on bus clock");
   property p_fast; fast_q >= 5'h10 |-> core_on_fast && core_clock_out == $past(fast_clock, 2);
   endproperty
   a_fast: assert property (p_fast) else $error("core not on fast clock");
   property p_rise; $rose(core_clock_out) |-> $past(bus_clock, 2) || $past(fast_clock, 2);
   endproperty
   a_rise: assert property (p_rise) else $error("core clock rose from no source");
   property p_swl; $changed(core_on_fast) |-> !core_clock_out || !$past(core_clock_out);
   endproperty
   a_swl: assert property (p_swl) else $error("switch while core clock high");
endmodule // ccs_chk
`default_nettype wire

// ===== dv/ccs_core_clock_select_tb.sv
// Testbench: walks modes and access kinds, halts clocks, checks flags.
// Assumes partner ccs_clk_gen and checker ccs_chk are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
   $display("FAIL %0t got %h exp %h", $time, a, e); end end
module ccs_core_clock_select_tb;
   import ccs_pkg::*;
   logic       clk_sys = 1'h0, rst_n = 1'h0, run = 1'h0, nb = 1'h0, asb = 1'h0;
   logic [1:0] acc = ACC_NONE;
   wire logic  bus_clock, fast_clock, cco, bif, cof, bom;
   logic [1:0] exp_q[$];
   int         failures = 0, checks = 0;
   logic [31:0] lfsr = 32'h00016D59;
   event       ev;
   always #12.5 clk_sys = ~clk_sys;
   ccs_clk_gen i_gen (.clk_sys, .rst_n, .run, .bus_clock, .fast_clock);
   ccs_core_clock_select i_dut (.clk_sys, .rst_n, .bus_clock, .fast_clock,
      .not_bus_only_bit(nb), .async_select_bit(asb), .access_type(acc),
      .core_clock_out(cco), .bus_if_clock(bif), .core_on_fast(cof),
      .bus_clock_only_mode(bom));
   function automatic logic [31:0] nxt(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic finish_test();
      $display("failures=%0d checks=%0d", failures, checks);
      if (failures == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic step(logic n, logic a, logic [1:0] t);
      int i;
      logic f;
      f = n && !t[1];
      @(posedge clk_sys);
      nb <= n;
      asb <= a;
      acc <= t;
      exp_q.push_back({!n, f});
      // Three edges at least: the mode flag lags the mode bit by two
      for (i = 0; i < 40; i++) begin
         @(posedge clk_sys);
         #1;
         if (i >= 2 && cof === f) break;
      end
      if (i == 40) begin
         failures++;
         finish_test();
      end else begin
         -> ev;
      end
   endtask
   always begin
      @(ev);
      `CHK({bom, cof}, exp_q.pop_front())
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'h1;
      run <= 1'h1;
      @(posedge clk_sys);
      #1 `CHK({bom, cof, cco, bif}, 4'h8)
      for (int k = 0; k < 16; k++) begin
         lfsr = nxt(lfsr);
         step(k[3] | k[2] | lfsr[1], lfsr[0], k[1:0]);
         if (k == 9) begin
            run <= 1'h0;
            repeat (30) @(posedge clk_sys);
            #1 `CHK(cof, 1'h1)
            run <= 1'h1;
         end
      end
      finish_test();
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      finish_test();
   end
endmodule // ccs_core_clock_select_tb
bind ccs_core_clock_select ccs_chk i_chk (.clk_sys, .rst_n, .bus_clock, .fast_clock,
   .not_bus_only_bit, .async_select_bit, .access_type, .core_clock_out,
   .bus_if_clock, .core_on_fast, .bus_clock_only_mode);
`default_nettype wire
